// File: design/reig_top.sv
// error record interrupt generator with apb control
`timescale 1ns/10ps
module reig_top #(
  parameter int                       NREC     = 2,
  parameter int                       CE_W     = 2,
  parameter int                       CNT_W    = 8,
  parameter logic [NREC-1:0]          HAS_CNT  = '1,
  parameter logic [reig_pkg::EV_W-1:0] EDGE_MODE = 3'h0
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   clk_en,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [NREC-1:0]        valid_flag,
  input  wire logic [NREC-1:0]        deferred_error_flag,
  input  wire logic [NREC-1:0]        uncorrected_error_flag,
  input  wire logic [NREC-1:0]        critical_error_flag,
  input  wire logic [NREC*CE_W-1:0]   ce_field,
  input  wire logic [NREC-1:0]        ovf_clear,
  input  wire logic [NREC-1:0]        rec_evt,
  input  wire logic [NREC-1:0]        rec_de,
  input  wire logic [NREC-1:0]        rec_ue,
  input  wire logic [NREC-1:0]        rec_ci,
  input  wire logic [NREC-1:0]        ce_count,
  output logic [NREC-1:0]             ovf_flag,
  output logic                        fault_irq,
  output logic                        recovery_irq,
  output logic                        critical_irq,
  output logic                        irq
);
  localparam int EW = reig_pkg::EV_W;
  logic [reig_pkg::CTRL_W-1:0] ctrl_q;
  logic [EW-1:0]               stat_q;
  logic [EW-1:0]               irq_en_q;
  logic [EW-1:0]               out_q;
  logic                        irq_q;
  logic [31:0]                 prdata_q;
  logic                        pready_q;
  logic                        pslverr_q;
  logic [NREC-1:0]             ovf_w;
  logic [NREC-1:0]             ce_evt_w;
  logic [EW-1:0]               lvl_r [NREC];
  logic [EW-1:0]               edg_r [NREC];
  logic [EW-1:0]               lvl_any;
  logic [EW-1:0]               edg_any;
  logic [EW-1:0]               out_d;
  logic                        wr_acc;
  logic                        rd_acc;
  logic                        addr_ok;

  genvar g;
  generate
    for (g = 0; g < NREC; g++) begin : g_rec
      reig_ce_counter #(.CNT_W(CNT_W)) u_cnt (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (clk_en),
        .count    (ce_count[g] && HAS_CNT[g]),
        .clr_ovf  (ovf_clear[g]),
        .ovf_q    (ovf_w[g]),
        .ce_evt_q (ce_evt_w[g]),
        .cnt_q    ()
      );
      reig_record #(.CE_W(CE_W)) u_rec (
        .en                     (clk_en),
        .ctrl                   (ctrl_q),
        .has_counter            (HAS_CNT[g]),
        .valid_flag             (valid_flag[g]),
        .deferred_error_flag    (deferred_error_flag[g]),
        .uncorrected_error_flag (uncorrected_error_flag[g]),
        .critical_error_flag    (critical_error_flag[g]),
        .ce_field               (ce_field[g*CE_W +: CE_W]),
        .ovf_flag               (ovf_w[g]),
        .rec_evt                (rec_evt[g]),
        .rec_de                 (rec_de[g]),
        .rec_ue                 (rec_ue[g]),
        .rec_ci                 (rec_ci[g]),
        // without a counter each corrected count is itself an event
        .ce_evt                 (HAS_CNT[g] ? ce_evt_w[g] : ce_count[g]),
        .lvl                    (lvl_r[g]),
        .edg                    (edg_r[g])
      );
    end
  endgenerate

  // all records merged onto one line per kind
  always_comb begin
    lvl_any = '0;
    edg_any = '0;
    for (int i = 0; i < NREC; i++) begin
      lvl_any = lvl_any | lvl_r[i];
      edg_any = edg_any | edg_r[i];
    end
    for (int k = 0; k < EW; k++) begin
      out_d[k] = EDGE_MODE[k] ? edg_any[k] : lvl_any[k];
    end
  end

  assign addr_ok = (paddr == reig_pkg::ADDR_CTRL)   ||
                   (paddr == reig_pkg::ADDR_STATUS) ||
                   (paddr == reig_pkg::ADDR_CLEAR)  ||
                   (paddr == reig_pkg::ADDR_IRQ_EN) ||
                   (paddr == reig_pkg::ADDR_LEVEL);
  assign wr_acc = psel && penable && pwrite && pready_q;
  assign rd_acc = psel && !penable && !pwrite;

  // outputs registered; edge outputs stay high one cycle for each cycle their strobe is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= reig_pkg::EV_RESET;
    end else if (clk_en) begin
      out_q <= out_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= reig_pkg::CTRL_RESET;
      irq_en_q <= reig_pkg::EV_RESET;
    end else if (clk_en && wr_acc) begin
      if (paddr == reig_pkg::ADDR_CTRL) begin
        ctrl_q <= pwdata[reig_pkg::CTRL_W-1:0];
      end
      if (paddr == reig_pkg::ADDR_IRQ_EN) begin
        irq_en_q <= pwdata[EW-1:0];
      end
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= reig_pkg::EV_RESET;
    end else if (clk_en) begin
      if (wr_acc && paddr == reig_pkg::ADDR_CLEAR) begin
        stat_q <= (stat_q & ~pwdata[EW-1:0]) | out_d;
      end else begin
        stat_q <= stat_q | out_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(stat_q & irq_en_q);
    end
  end

  // no wait states: setup cycle prepares data, access completes in its first cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= reig_pkg::RD_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !addr_ok;
      if (rd_acc) begin
        prdata_q <= reig_pkg::RD_ZERO;
        unique case (paddr)
          reig_pkg::ADDR_CTRL:   prdata_q[reig_pkg::CTRL_W-1:0] <= ctrl_q;
          reig_pkg::ADDR_STATUS: prdata_q[EW-1:0] <= stat_q;
          reig_pkg::ADDR_IRQ_EN: prdata_q[EW-1:0] <= irq_en_q;
          reig_pkg::ADDR_LEVEL:  prdata_q[EW-1:0] <= lvl_any;
          default:               prdata_q <= reig_pkg::RD_ZERO;
        endcase
      end
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign ovf_flag     = ovf_w;
  // integrator routes these, ideally as private core interrupts
  assign fault_irq    = out_q[reig_pkg::EV_FH];
  assign recovery_irq = out_q[reig_pkg::EV_ER];
  assign critical_irq = out_q[reig_pkg::EV_CRIT];
  assign irq          = irq_q;

  a_crit_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !EDGE_MODE[reig_pkg::EV_CRIT]) |=>
    (critical_irq == $past(lvl_any[reig_pkg::EV_CRIT])))
    else $error("critical level output mismatch");

  a_crit_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && EDGE_MODE[reig_pkg::EV_CRIT] && ctrl_q[reig_pkg::CTRL_CRIT]
     && rec_evt[0] && rec_ci[0]) |=> critical_irq)
    else $error("critical pulse missing");

  a_fh_du_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && EDGE_MODE[reig_pkg::EV_FH] && ctrl_q[reig_pkg::CTRL_FH_DU]
     && rec_evt[0] && (rec_de[0] || rec_ue[0])) |=> fault_irq)
    else $error("fault pulse missing");

  a_er_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && EDGE_MODE[reig_pkg::EV_ER] && rec_evt[0] &&
     ((ctrl_q[reig_pkg::CTRL_ER_UE] && rec_ue[0]) ||
      (ctrl_q[reig_pkg::CTRL_ER_DE] && rec_de[0]))) |=> recovery_irq)
    else $error("recovery pulse missing");

  a_er_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !EDGE_MODE[reig_pkg::EV_ER] && valid_flag[0] &&
     ctrl_q[reig_pkg::CTRL_ER_UE] && uncorrected_error_flag[0])
    |=> recovery_irq)
    else $error("recovery level missing");

  a_fh_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !EDGE_MODE[reig_pkg::EV_FH] && valid_flag[0] &&
     ctrl_q[reig_pkg::CTRL_FH_DU] && deferred_error_flag[0])
    |=> fault_irq)
    else $error("fault level missing");

  a_no_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && ctrl_q == '0) |=> (out_q == '0))
    else $error("interrupt without enable");

  a_ovf_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && HAS_CNT[0] && ce_count[0] && g_rec[0].u_cnt.cnt_q == '1)
    |=> (ovf_flag[0] && ce_evt_w[0]))
    else $error("overflow flag not set");

  a_pulse_once: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && EDGE_MODE[reig_pkg::EV_CRIT] && critical_irq &&
     (rec_evt & rec_ci) == '0) |=> !critical_irq)
    else $error("critical pulse too long");

  a_fh_ue_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !EDGE_MODE[reig_pkg::EV_FH] && valid_flag[NREC-1] &&
     ctrl_q[reig_pkg::CTRL_FH_DU] && uncorrected_error_flag[NREC-1])
    |=> fault_irq)
    else $error("fault level on uncorrected missing");

  a_fh_ovf_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !EDGE_MODE[reig_pkg::EV_FH] && HAS_CNT[0] && valid_flag[0] &&
     ctrl_q[reig_pkg::CTRL_FH_CE] && ovf_w[0]) |=> fault_irq)
    else $error("fault level on overflow missing");

  a_fh_ce_field: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !EDGE_MODE[reig_pkg::EV_FH] && !HAS_CNT[NREC-1] &&
     valid_flag[NREC-1] && ctrl_q[reig_pkg::CTRL_FH_CE] &&
     ce_field[(NREC-1)*CE_W +: CE_W] != '0) |=> fault_irq)
    else $error("fault level on corrected field missing");

  a_fh_ce_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && EDGE_MODE[reig_pkg::EV_FH] && ctrl_q[reig_pkg::CTRL_FH_CE] &&
     ce_evt_w[0] && HAS_CNT[0]) |=> fault_irq)
    else $error("fault pulse on corrected event missing");

  a_er_de_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !EDGE_MODE[reig_pkg::EV_ER] && valid_flag[0] &&
     ctrl_q[reig_pkg::CTRL_ER_DE] && deferred_error_flag[0])
    |=> recovery_irq)
    else $error("recovery level on deferred missing");

  a_crit_merged: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && !EDGE_MODE[reig_pkg::EV_CRIT] && ctrl_q[reig_pkg::CTRL_CRIT] &&
     valid_flag[NREC-1] && critical_error_flag[NREC-1]) |=> critical_irq)
    else $error("critical level of last record missing");

  a_crit_rec_new: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && EDGE_MODE[reig_pkg::EV_CRIT] && ctrl_q[reig_pkg::CTRL_CRIT] &&
     rec_evt[NREC-1] && rec_ci[NREC-1]) |=> critical_irq)
    else $error("critical pulse of last record missing");

  a_er_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && EDGE_MODE[reig_pkg::EV_ER] && rec_evt == '0) |=> !recovery_irq)
    else $error("recovery pulse without recording");

  a_fh_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && EDGE_MODE[reig_pkg::EV_FH] && rec_evt == '0 &&
     ce_evt_w == '0 && (ce_count & ~HAS_CNT) == '0) |=> !fault_irq)
    else $error("fault pulse without event");

  a_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!clk_en) |=> ($stable(out_q) && $stable(stat_q) && $stable(ctrl_q) &&
     $stable(irq_en_q) && $stable(irq_q) && $stable(ovf_w)))
    else $error("state moved while clock enable low");

  a_irq_masked: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && irq_en_q == '0) |=> !irq)
    else $error("interrupt with all enables cleared");

  a_stat_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clk_en && out_d[reig_pkg::EV_CRIT]) |=> stat_q[reig_pkg::EV_CRIT])
    else $error("critical status bit lost");
endmodule

// File: design/reig_pkg.sv
// constants and types for the error record interrupt generator
// How it works
// - level fault irq: valid and deferred or uncorrected, when enabled
// - level fault irq on corrected: valid and counter overflow, counter present
// - level fault irq on corrected without counter: valid and corrected nonzero
// - level recovery irq: valid and uncorrected or deferred with matching enable
// - level critical irq: enabled, valid and critical flag set
// - edge fault pulse on deferred or uncorrected recording when enabled
// - edge fault pulse on corrected error event when enabled
// - edge recovery pulse on uncorrected recording when enabled
// - edge recovery pulse on deferred recording when enabled
// - edge critical pulse on recording that sets critical flag, when enabled
// - edge critical pulse even if critical flag already set
// - each output edge or level, fixed by a parameter
// - outputs combined across records only; combined reflects every record
// - system-register-only records suggest private per-core interrupts
// - counter unsigned overflow sets overflow flag and raises corrected event
// - edge pulse produced even when syndrome dropped for higher priority
package reig_pkg;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_CLEAR   = 12'h008;
  localparam logic [11:0] ADDR_IRQ_EN  = 12'h00C;
  localparam logic [11:0] ADDR_LEVEL   = 12'h010;
  // ctrl bit positions
  localparam int CTRL_FH_DU  = 0;
  localparam int CTRL_FH_CE  = 1;
  localparam int CTRL_ER_UE  = 2;
  localparam int CTRL_ER_DE  = 3;
  localparam int CTRL_CRIT   = 4;
  localparam int CTRL_W      = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  // status event bits
  localparam int EV_FH   = 0;
  localparam int EV_ER   = 1;
  localparam int EV_CRIT = 2;
  localparam int EV_W    = 3;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// File: design/reig_record.sv
// one error record's interrupt conditions
`timescale 1ns/10ps
module reig_record #(
  parameter int CE_W = 2
) (
  input  wire logic                          en,
  input  wire logic [reig_pkg::CTRL_W-1:0]   ctrl,
  input  wire logic                          has_counter,
  input  wire logic                          valid_flag,
  input  wire logic                          deferred_error_flag,
  input  wire logic                          uncorrected_error_flag,
  input  wire logic                          critical_error_flag,
  input  wire logic [CE_W-1:0]               ce_field,
  input  wire logic                          ovf_flag,
  input  wire logic                          rec_evt,
  input  wire logic                          rec_de,
  input  wire logic                          rec_ue,
  input  wire logic                          rec_ci,
  input  wire logic                          ce_evt,
  output logic [reig_pkg::EV_W-1:0]          lvl,
  output logic [reig_pkg::EV_W-1:0]          edg
);
  logic ce_cond;
  always_comb begin
    ce_cond = has_counter ? ovf_flag : (ce_field != '0);
    lvl[reig_pkg::EV_FH] = valid_flag &&
      ((ctrl[reig_pkg::CTRL_FH_DU] &&
        (deferred_error_flag || uncorrected_error_flag)) ||
       (ctrl[reig_pkg::CTRL_FH_CE] && ce_cond));
    lvl[reig_pkg::EV_ER] = valid_flag &&
      ((ctrl[reig_pkg::CTRL_ER_UE] && uncorrected_error_flag) ||
       (ctrl[reig_pkg::CTRL_ER_DE] && deferred_error_flag));
    lvl[reig_pkg::EV_CRIT] = ctrl[reig_pkg::CTRL_CRIT] && valid_flag &&
      critical_error_flag;
    // recording strobe used regardless of syndrome kept or dropped
    edg[reig_pkg::EV_FH] = en &&
      ((ctrl[reig_pkg::CTRL_FH_DU] && rec_evt && (rec_de || rec_ue)) ||
       (ctrl[reig_pkg::CTRL_FH_CE] && ce_evt));
    edg[reig_pkg::EV_ER] = en && rec_evt &&
      ((ctrl[reig_pkg::CTRL_ER_UE] && rec_ue) ||
       (ctrl[reig_pkg::CTRL_ER_DE] && rec_de));
    // old flag value not consulted
    edg[reig_pkg::EV_CRIT] = en && rec_evt && rec_ci &&
      ctrl[reig_pkg::CTRL_CRIT];
  end
endmodule

// File: design/reig_ce_counter.sv
// corrected error counter with overflow flag
`timescale 1ns/10ps
module reig_ce_counter #(
  parameter int CNT_W = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             en,
  input  wire logic             count,
  input  wire logic             clr_ovf,
  output logic                  ovf_q,
  output logic                  ce_evt_q,
  output logic [CNT_W-1:0]      cnt_q
);
  logic wrap;
  assign wrap = count && (cnt_q == '1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= '0;
      ovf_q    <= 1'b0;
      ce_evt_q <= 1'b0;
    end else if (en) begin
      if (count) begin
        cnt_q <= cnt_q + 1'b1;
      end
      // overflow set wins over a clear in the same cycle
      if (wrap) begin
        ovf_q <= 1'b1;
      end else if (clr_ovf) begin
        ovf_q <= 1'b0;
      end
      ce_evt_q <= wrap;
    end
  end
endmodule

// File: verif/reig_irq_sink.sv
// interrupt receiver model: counts high cycles on each error line
`timescale 1ns/10ps
module reig_irq_sink (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fault_irq,
  input  wire logic recovery_irq,
  input  wire logic critical_irq,
  output int        n_fault,
  output int        n_recovery,
  output int        n_critical
);
  // counts cycles, not edges: a stretched pulse shows up as two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_fault <= 0;
      n_recovery <= 0;
      n_critical <= 0;
    end else begin
      n_fault <= n_fault + int'(fault_irq);
      n_recovery <= n_recovery + int'(recovery_irq);
      n_critical <= n_critical + int'(critical_irq);
    end
  end
endmodule

// File: verif/reig_top_tb.sv
// self-checking bench for the error record interrupt generator
`timescale 1ns/10ps
module reig_top_tb;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        clk_en = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr;
  logic [1:0]  vf = 2'h0, df = 2'h0, uf = 2'h0, cf = 2'h0;
  logic [3:0]  cef = 4'h0;
  logic [1:0]  oclr = 2'h0, rev = 2'h0, rde = 2'h0, rue = 2'h0;
  logic [1:0]  rci = 2'h0, cnt = 2'h0, ovf;
  logic        fh, er, cr, irq, e_fh, e_er, e_cr;
  int          n_fh, n_er, n_cr, s_f, s_r, s_c;
  int          n_errors = 0;
  int          checks = 0;

  always #12.5 pclk = ~pclk;

  // level instance; record 1 has no counter so the field path is reachable
  reig_top #(.CNT_W(2), .HAS_CNT(2'h1)) u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .valid_flag(vf), .deferred_error_flag(df), .uncorrected_error_flag(uf),
    .critical_error_flag(cf), .ce_field(cef), .ovf_clear(oclr),
    .rec_evt(rev), .rec_de(rde), .rec_ue(rue), .rec_ci(rci),
    .ce_count(cnt), .ovf_flag(ovf), .fault_irq(fh), .recovery_irq(er),
    .critical_irq(cr), .irq(irq));
  // edge instance shares every input with the level one
  reig_top #(.CNT_W(2), .EDGE_MODE(3'h7)) u_dut_edge (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(),
    .valid_flag(vf), .deferred_error_flag(df), .uncorrected_error_flag(uf),
    .critical_error_flag(cf), .ce_field(cef), .ovf_clear(oclr),
    .rec_evt(rev), .rec_de(rde), .rec_ue(rue), .rec_ci(rci),
    .ce_count(cnt), .ovf_flag(), .fault_irq(e_fh), .recovery_irq(e_er),
    .critical_irq(e_cr), .irq());
  reig_irq_sink u_sink (
    .pclk(pclk), .presetn(presetn), .fault_irq(e_fh),
    .recovery_irq(e_er), .critical_irq(e_cr), .n_fault(n_fh),
    .n_recovery(n_er), .n_critical(n_cr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) n_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic e_err);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
    chk(rerr, e_err);
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic flags(input logic [1:0] v, d, u, c, input logic [3:0] e);
    @(posedge pclk);
    vf <= v;
    df <= d;
    uf <= u;
    cf <= c;
    cef <= e;
    settle();
  endtask
  task automatic rec(input logic [1:0] r, input logic d, u, c);
    @(posedge pclk);
    rev <= r;
    rde <= {2{d}};
    rue <= {2{u}};
    rci <= {2{c}};
    @(posedge pclk);
    rev <= 2'h0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic count(input int n);
    @(posedge pclk);
    cnt <= 2'h1;
    repeat (n) @(posedge pclk);
    cnt <= 2'h0;
    settle();
  endtask
  task automatic snap;
    s_f = n_fh;
    s_r = n_er;
    s_c = n_cr;
  endtask
  // pulse counts since the last snapshot
  task automatic pul(input int f, r, c);
    chk(n_fh - s_f, f);
    chk(n_er - s_r, r);
    chk(n_cr - s_c, c);
    snap();
  endtask

  task automatic t_fault;
    wr(reig_pkg::ADDR_CTRL, 32'h1);
    flags(2'h2, 2'h0, 2'h2, 2'h0, 4'h0);
    chk(fh, 1'h1);
    chk(er, 1'h0);
    flags(2'h1, 2'h0, 2'h2, 2'h0, 4'h0);
    chk(fh, 1'h0);
    flags(2'h3, 2'h1, 2'h0, 2'h0, 4'h0);
    chk(fh, 1'h1);
    $display("fault level test done");
  endtask
  task automatic t_ce;
    wr(reig_pkg::ADDR_CTRL, 32'h2);
    flags(2'h2, 2'h0, 2'h0, 2'h0, 4'h4);
    chk(fh, 1'h1);
    flags(2'h1, 2'h0, 2'h0, 2'h0, 4'h0);
    chk(fh, 1'h0);
    snap();
    count(3);
    chk(ovf, 2'h0);
    count(1);
    chk(ovf, 2'h1);
    chk(fh, 1'h1);
    pul(1, 0, 0);
    @(posedge pclk);
    oclr <= 2'h1;
    @(posedge pclk);
    oclr <= 2'h0;
    settle();
    chk(fh, 1'h0);
    $display("corrected error test done");
  endtask
  task automatic t_recov;
    wr(reig_pkg::ADDR_CTRL, 32'h4);
    flags(2'h1, 2'h1, 2'h0, 2'h0, 4'h0);
    chk(er, 1'h0);
    wr(reig_pkg::ADDR_CTRL, 32'h8);
    settle();
    chk(er, 1'h1);
    flags(2'h3, 2'h0, 2'h2, 2'h0, 4'h0);
    chk(er, 1'h0);
    wr(reig_pkg::ADDR_CTRL, 32'h4);
    settle();
    chk(er, 1'h1);
    flags(2'h0, 2'h0, 2'h0, 2'h0, 4'h0);
    $display("recovery level test done");
  endtask
  task automatic t_edge;
    wr(reig_pkg::ADDR_CTRL, 32'h1F);
    snap();
    rec(2'h1, 1'h1, 1'h0, 1'h0);
    pul(1, 1, 0);
    rec(2'h2, 1'h0, 1'h1, 1'h0);
    pul(1, 1, 0);
    flags(2'h1, 2'h0, 2'h0, 2'h1, 4'h0);
    rec(2'h1, 1'h0, 1'h0, 1'h1);
    rec(2'h2, 1'h0, 1'h0, 1'h1);
    pul(0, 0, 2);
    wr(reig_pkg::ADDR_CTRL, 32'h0);
    rec(2'h3, 1'h1, 1'h1, 1'h1);
    pul(0, 0, 0);
    flags(2'h0, 2'h0, 2'h0, 2'h0, 4'h0);
    $display("edge test done");
  endtask
  // enable low holds every output; strobes seen then are lost
  task automatic t_freeze;
    wr(reig_pkg::ADDR_CTRL, 32'h1F);
    snap();
    @(posedge pclk);
    clk_en <= 1'h0;
    flags(2'h1, 2'h1, 2'h0, 2'h0, 4'h0);
    chk(fh, 1'h0);
    rec(2'h1, 1'h1, 1'h0, 1'h0);
    pul(0, 0, 0);
    @(posedge pclk);
    clk_en <= 1'h1;
    settle();
    chk(fh, 1'h1);
    chk(er, 1'h1);
    pul(0, 0, 0);
    flags(2'h0, 2'h0, 2'h0, 2'h0, 4'h0);
    wr(reig_pkg::ADDR_CTRL, 32'h0);
    $display("clock enable test done");
  endtask
  task automatic t_irq;
    wr(reig_pkg::ADDR_CTRL, 32'h10);
    wr(reig_pkg::ADDR_CLEAR, 32'h7);
    wr(reig_pkg::ADDR_IRQ_EN, 32'h4);
    flags(2'h2, 2'h0, 2'h0, 2'h2, 4'h0);
    settle();
    chk(cr, 1'h1);
    chk(irq, 1'h1);
    rd(reig_pkg::ADDR_STATUS, 32'h4, 1'h0);
    rd(reig_pkg::ADDR_LEVEL, 32'h4, 1'h0);
    wr(reig_pkg::ADDR_IRQ_EN, 32'h0);
    settle();
    chk(irq, 1'h0);
    wr(reig_pkg::ADDR_IRQ_EN, 32'h4);
    flags(2'h0, 2'h0, 2'h0, 2'h2, 4'h0);
    chk(cr, 1'h0);
    wr(reig_pkg::ADDR_CLEAR, 32'h4);
    settle();
    chk(irq, 1'h0);
    rd(reig_pkg::ADDR_STATUS, 32'h0, 1'h0);
    rd(reig_pkg::ADDR_CLEAR, 32'h0, 1'h0);
    rd(12'h020, 32'h0, 1'h1);
    $display("interrupt register test done");
  endtask

  task automatic end_of_test;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    chk({fh, er, cr, irq}, 4'h0);
    rd(reig_pkg::ADDR_CTRL, 32'h0, 1'h0);
    rd(reig_pkg::ADDR_IRQ_EN, 32'h0, 1'h0);
    $display("reset test done");
    t_fault();
    t_ce();
    t_recov();
    t_edge();
    t_freeze();
    t_irq();
    end_of_test();
  end
  // whole run is under two hundred cycles; this 2000-cycle limit is ample
  initial begin
    #50000;
    n_errors++;
    end_of_test();
  end
endmodule
